//--- pmcs_pkg.sv
// constants and carrier types for the power-mode clock switch
package pmcs_pkg;
  // register byte addresses on the axi4-lite slave
  localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TMR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_FEATURES = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  // oscillator_control_reg fields
  localparam int OSC_IDLE_BIT = 7;
  localparam int OSC_PRI_ACT_BIT = 3;
  localparam int OSC_SEL_LSB = 0;
  // secondary_timer_control_reg fields
  localparam int TMR_SEC_ACT_BIT = 6;
  localparam int TMR_SEC_EN_BIT = 3;
  // feature register fields
  localparam int FEAT_CFG_LSB = 0;
  localparam int FEAT_WDT_BIT = 4;
  localparam int FEAT_FSCM_BIT = 5;
  localparam int FEAT_TWOSPD_BIT = 6;
  // primary_osc_config bit that marks a crystal primary
  localparam int CFG_XTAL_BIT = 2;
  // clock source select encodings
  localparam logic [1:0] SRC_PRI = 2'h0;
  localparam logic [1:0] SRC_SEC = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h3;
  // reset values
  localparam logic [2:0] CFG_RESET = 3'h4;
  // switch timing in cycles of the old and new source
  localparam logic [2:0] DRAIN_EDGES = 3'h2;
  localparam logic [2:0] FILL_EDGES = 3'h3;
  localparam int OST_CYCLES = 1024;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // switch sequencer states
  typedef enum logic [2:0] {
    SW_RUN = 3'b000,
    SW_PRESTART = 3'b001,
    SW_DRAIN = 3'b010,
    SW_WAIT = 3'b011,
    SW_FILL = 3'b100,
    SW_LOWPOW = 3'b101
  } pmcs_state_type;
  // software-owned control bits
  typedef struct packed {
    logic idle_on_sleep;
    logic [1:0] clock_source_select;
    logic secondary_osc_enable;
    logic watchdog_enable;
    logic failsafe_enable;
    logic two_speed_enable;
    logic [2:0] primary_osc_config;
  } pmcs_ctrl_type;
  // one bit per oscillator source
  typedef struct packed {
    logic pri;
    logic sec;
    logic intl;
  } pmcs_osc_type;
endpackage

//--- pmcs_clock_switch.sv
// power-mode and clock-source switch controller with axi4-lite registers
`timescale 1ns/100ps
module pmcs_clock_switch #(
  parameter int OST_COUNT = pmcs_pkg::OST_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pmcs_pkg::pmcs_osc_type osc_in,
  input wire logic secondary_osc_running,
  input wire logic sleep_exec,
  input wire logic wake_event,
  output logic cpu_clk,
  output logic periph_clk,
  output logic primary_osc_enable,
  output logic secondary_osc_enable_out,
  output logic internal_osc_block_enable,
  output logic low_freq_internal_osc_enable
);
  // synchroniser stages for the oscillator levels and secondary running flag
  pmcs_pkg::pmcs_osc_type osc_s1, osc_s2, osc_d;
  logic secrun_s1, secrun_s2;
  // software control
  pmcs_pkg::pmcs_ctrl_type ctrl, next_ctrl;
  // sequencer state
  pmcs_pkg::pmcs_state_type state, next_state;
  logic [1:0] cur_src, next_cur_src; // source feeding the clocks
  logic [1:0] tgt_src, next_tgt_src; // source being switched to
  logic [2:0] edge_cnt, next_edge_cnt; // old/new source edge counter
  logic lp_idle, next_lp_idle; // low power is idle, not sleep
  logic asleep, next_asleep; // sleep entered, flags cleared
  logic [11:0] ost_cnt, next_ost_cnt; // start-up timer
  logic g_cpu, next_g_cpu, g_per, next_g_per; // clock gates
  logic next_cpu_clk, next_per_clk;
  // axi slave state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [3:0] wr_addr, next_wr_addr;
  logic [7:0] wr_byte, next_wr_byte;
  logic wr_lane, next_wr_lane;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  // derived signals
  logic cur_lvl; // level of the source now feeding the clocks
  logic cur_rise; // rising edge of that source
  logic pri_rise; // rising edge of the primary, feeds the start-up timer
  logic sel_ok; // select names a usable source other than the current one
  logic pri_act; // primary is feeding the clocks
  logic sec_act; // secondary is feeding the clocks
  logic aw_fire; // write address handshake
  logic w_fire; // write data handshake
  logic ar_fire; // read address handshake
  logic wr_do; // both write halves held, commit this cycle
  logic [31:0] rd_word; // read data before it is registered
  logic next_pri_en; // next primary oscillator enable
  logic next_sec_en; // next secondary oscillator enable
  logic next_int_en; // next internal block enable
  logic next_lf_en; // next low-frequency oscillator enable

  // level of one synchronised source; the unused select code falls to internal
  function automatic logic src_level(
    input pmcs_pkg::pmcs_osc_type osc,
    input logic [1:0] sel
  );
    logic lvl;
    lvl = osc.intl;
    if (sel == pmcs_pkg::SRC_PRI) begin
      lvl = osc.pri;
    end else if (sel == pmcs_pkg::SRC_SEC) begin
      lvl = osc.sec;
    end
    return lvl;
  endfunction

  // only word-aligned offsets exist; anything else answers slverr
  function automatic logic [1:0] resp_for(input logic [3:0] addr);
    logic [1:0] resp;
    resp = pmcs_pkg::RESP_SLVERR;
    if (addr[1:0] == 2'h0) begin
      resp = pmcs_pkg::RESP_OKAY;
    end
    return resp;
  endfunction

  // two flops on every oscillator level, a third only for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1 <= '0;
      osc_s2 <= '0;
      osc_d <= '0;
      secrun_s1 <= 1'b0;
      secrun_s2 <= 1'b0;
    end else begin
      osc_s1 <= osc_in;
      osc_s2 <= osc_s1;
      osc_d <= osc_s2;
      secrun_s1 <= secondary_osc_running;
      secrun_s2 <= secrun_s1;
    end
  end

  // edge detection on the synchronised levels
  assign cur_lvl = src_level(osc_s2, cur_src);
  assign cur_rise = cur_lvl & ~src_level(osc_d, cur_src);
  assign pri_rise = osc_s2.pri & ~osc_d.pri;

  // status flags follow the source in use; both drop while asleep
  assign pri_act = ~asleep & (cur_src == pmcs_pkg::SRC_PRI) &
                   (state != pmcs_pkg::SW_FILL) & (state != pmcs_pkg::SW_WAIT);
  assign sec_act = ~asleep & (cur_src == pmcs_pkg::SRC_SEC) &
                   (state != pmcs_pkg::SW_FILL) & (state != pmcs_pkg::SW_WAIT);

  // decide whether a new select value may start a switch
  always_comb begin
    sel_ok = 1'b0;
    if (ctrl.clock_source_select != cur_src &&
        ctrl.clock_source_select inside {pmcs_pkg::SRC_PRI, pmcs_pkg::SRC_SEC,
                                         pmcs_pkg::SRC_INT}) begin
      sel_ok = 1'b1;
    end
    // secondary not enabled: the request is simply not acted on
    if (ctrl.clock_source_select == pmcs_pkg::SRC_SEC && !ctrl.secondary_osc_enable) begin
      sel_ok = 1'b0;
    end
  end

  // switch sequencer next state
  always_comb begin
    next_state = state;
    next_cur_src = cur_src;
    next_tgt_src = tgt_src;
    next_edge_cnt = edge_cnt;
    next_lp_idle = lp_idle;
    next_asleep = asleep;
    next_ost_cnt = ost_cnt;
    next_g_cpu = g_cpu;
    next_g_per = g_per;
    unique case (state)
      pmcs_pkg::SW_RUN: begin
        // sleep wins over a pending switch; a sleep_exec arriving outside run is not acted on
        if (sleep_exec) begin
          next_state = pmcs_pkg::SW_LOWPOW;
          next_lp_idle = ctrl.idle_on_sleep;
          next_asleep = ~ctrl.idle_on_sleep;
        end else if (sel_ok) begin
          next_tgt_src = ctrl.clock_source_select;
          next_edge_cnt = 3'h0;
          next_ost_cnt = 12'h0;
          if (ctrl.clock_source_select == pmcs_pkg::SRC_PRI) begin
            next_state = pmcs_pkg::SW_PRESTART;
          end else begin
            next_state = pmcs_pkg::SW_DRAIN;
          end
        end
      end
      pmcs_pkg::SW_PRESTART: begin
        // old source keeps clocking while the primary starts
        if (!ctrl.primary_osc_config[pmcs_pkg::CFG_XTAL_BIT]) begin
          next_state = pmcs_pkg::SW_DRAIN;
        end else if (pri_rise) begin
          if (ost_cnt == 12'(OST_COUNT - 1)) begin
            next_state = pmcs_pkg::SW_DRAIN;
          end else begin
            next_ost_cnt = ost_cnt + 12'h1;
          end
        end
      end
      pmcs_pkg::SW_DRAIN: begin
        // two edges of the old source, then cut only while it is low
        if (edge_cnt == pmcs_pkg::DRAIN_EDGES) begin
          if (!cur_lvl) begin
            next_g_cpu = 1'b0;
            next_g_per = 1'b0;
            next_cur_src = tgt_src;
            next_edge_cnt = 3'h0;
            if (tgt_src == pmcs_pkg::SRC_SEC && !secrun_s2) begin
              next_state = pmcs_pkg::SW_WAIT;
            end else begin
              next_state = pmcs_pkg::SW_FILL;
            end
          end
        end else if (cur_rise) begin
          next_edge_cnt = edge_cnt + 3'h1;
        end
      end
      pmcs_pkg::SW_WAIT: begin
        // clocks stay off until the secondary oscillates
        if (secrun_s2) begin
          next_state = pmcs_pkg::SW_FILL;
        end
      end
      pmcs_pkg::SW_FILL: begin
        // edges of the new source, then reopen while it is low
        if (edge_cnt == pmcs_pkg::FILL_EDGES) begin
          if (!cur_lvl) begin
            next_g_cpu = 1'b1;
            next_g_per = 1'b1;
            next_lp_idle = 1'b0;
            next_edge_cnt = 3'h0;
            next_state = pmcs_pkg::SW_RUN;
          end
        end else if (cur_rise) begin
          next_edge_cnt = edge_cnt + 3'h1;
        end
      end
      pmcs_pkg::SW_LOWPOW: begin
        if (wake_event) begin
          next_asleep = 1'b0;
          next_edge_cnt = 3'h0;
          next_state = pmcs_pkg::SW_FILL;
        end else if (!cur_lvl) begin
          next_g_cpu = 1'b0;
          next_g_per = lp_idle;
        end
      end
      default: begin
        // unused codes fall back to run
        next_state = pmcs_pkg::SW_RUN;
      end
    endcase
  end

  // gated clocks and oscillator enables
  always_comb begin
    next_cpu_clk = g_cpu & cur_lvl;
    next_per_clk = g_per & cur_lvl;
    next_pri_en = ~next_asleep & ((next_cur_src == pmcs_pkg::SRC_PRI) |
                                  (next_tgt_src == pmcs_pkg::SRC_PRI));
    next_int_en = ~next_asleep & ((next_cur_src == pmcs_pkg::SRC_INT) |
                                  (next_tgt_src == pmcs_pkg::SRC_INT));
    next_sec_en = ctrl.secondary_osc_enable;
    next_lf_en = ctrl.watchdog_enable | ctrl.failsafe_enable;
  end

  // sequencer registers; reset lands in primary run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= pmcs_pkg::SW_RUN;
      cur_src <= pmcs_pkg::SRC_PRI;
      tgt_src <= pmcs_pkg::SRC_PRI;
      edge_cnt <= 3'h0;
      lp_idle <= 1'b0;
      asleep <= 1'b0;
      ost_cnt <= 12'h0;
      g_cpu <= 1'b1;
      g_per <= 1'b1;
      cpu_clk <= 1'b0;
      periph_clk <= 1'b0;
      primary_osc_enable <= 1'b1;
      secondary_osc_enable_out <= 1'b0;
      internal_osc_block_enable <= 1'b0;
      low_freq_internal_osc_enable <= 1'b0;
    end else begin
      state <= next_state;
      cur_src <= next_cur_src;
      tgt_src <= next_tgt_src;
      edge_cnt <= next_edge_cnt;
      lp_idle <= next_lp_idle;
      asleep <= next_asleep;
      ost_cnt <= next_ost_cnt;
      g_cpu <= next_g_cpu;
      g_per <= next_g_per;
      cpu_clk <= next_cpu_clk;
      periph_clk <= next_per_clk;
      primary_osc_enable <= next_pri_en;
      secondary_osc_enable_out <= next_sec_en;
      internal_osc_block_enable <= next_int_en;
      low_freq_internal_osc_enable <= next_lf_en;
    end
  end

  // axi4-lite handshakes; one write and one read in flight at most
  assign s_axi_awready = ~aw_held & ~bvalid;
  assign s_axi_wready = ~w_held & ~bvalid;
  assign s_axi_arready = ~rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;

  // read mux; flags are read-only views of the sequencer
  always_comb begin
    rd_word = 32'h0;
    unique case (s_axi_araddr)
      pmcs_pkg::ADDR_OSC_CTRL: begin
        rd_word[pmcs_pkg::OSC_IDLE_BIT] = ctrl.idle_on_sleep;
        rd_word[pmcs_pkg::OSC_PRI_ACT_BIT] = pri_act;
        rd_word[pmcs_pkg::OSC_SEL_LSB +: 2] = ctrl.clock_source_select;
      end
      pmcs_pkg::ADDR_TMR_CTRL: begin
        rd_word[pmcs_pkg::TMR_SEC_ACT_BIT] = sec_act;
        rd_word[pmcs_pkg::TMR_SEC_EN_BIT] = ctrl.secondary_osc_enable;
      end
      pmcs_pkg::ADDR_FEATURES: begin
        rd_word[pmcs_pkg::FEAT_CFG_LSB +: 3] = ctrl.primary_osc_config;
        rd_word[pmcs_pkg::FEAT_WDT_BIT] = ctrl.watchdog_enable;
        rd_word[pmcs_pkg::FEAT_FSCM_BIT] = ctrl.failsafe_enable;
        rd_word[pmcs_pkg::FEAT_TWOSPD_BIT] = ctrl.two_speed_enable;
      end
      pmcs_pkg::ADDR_STATUS: begin
        rd_word[2:0] = state;
        rd_word[5:4] = cur_src;
        rd_word[8] = lp_idle;
        rd_word[9] = asleep;
      end
      default: begin
        // misaligned offsets read as zero
        rd_word = 32'h0;
      end
    endcase
  end

  // axi channel next state; response one cycle after both halves are held
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr_addr = wr_addr;
    next_wr_byte = wr_byte;
    next_wr_lane = wr_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    wr_do = 1'b0;
    if (aw_fire) begin
      next_aw_held = 1'b1;
      next_wr_addr = s_axi_awaddr;
    end
    if (w_fire) begin
      next_w_held = 1'b1;
      next_wr_byte = s_axi_wdata[7:0];
      next_wr_lane = s_axi_wstrb[0];
    end
    if (aw_held & w_held) begin
      wr_do = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = resp_for(wr_addr);
    end else if (bvalid & s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (ar_fire) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = resp_for(s_axi_araddr);
    end else if (rvalid & s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // software control; only bus writes touch it, never a switch or wake
  always_comb begin
    next_ctrl = ctrl;
    if (wr_do & wr_lane) begin
      unique case (wr_addr)
        pmcs_pkg::ADDR_OSC_CTRL: begin
          next_ctrl.idle_on_sleep = wr_byte[pmcs_pkg::OSC_IDLE_BIT];
          next_ctrl.clock_source_select = wr_byte[pmcs_pkg::OSC_SEL_LSB +: 2];
        end
        pmcs_pkg::ADDR_TMR_CTRL: begin
          next_ctrl.secondary_osc_enable = wr_byte[pmcs_pkg::TMR_SEC_EN_BIT];
        end
        pmcs_pkg::ADDR_FEATURES: begin
          next_ctrl.primary_osc_config = wr_byte[pmcs_pkg::FEAT_CFG_LSB +: 3];
          next_ctrl.watchdog_enable = wr_byte[pmcs_pkg::FEAT_WDT_BIT];
          next_ctrl.failsafe_enable = wr_byte[pmcs_pkg::FEAT_FSCM_BIT];
          next_ctrl.two_speed_enable = wr_byte[pmcs_pkg::FEAT_TWOSPD_BIT];
        end
        default: begin
          // status and misaligned offsets ignore writes
          next_ctrl = ctrl;
        end
      endcase
    end
  end

  // bus and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '{idle_on_sleep: 1'b0, clock_source_select: pmcs_pkg::SRC_PRI,
                secondary_osc_enable: 1'b0, watchdog_enable: 1'b0, failsafe_enable: 1'b0,
                two_speed_enable: 1'b0, primary_osc_config: pmcs_pkg::CFG_RESET};
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 4'h0;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= pmcs_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= pmcs_pkg::RESP_OKAY;
      rdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_byte <= next_wr_byte;
      wr_lane <= next_wr_lane;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end
endmodule // pmcs_clock_switch

//--- pmcs_chk.sv
// assertions on the switch ports
`timescale 1ns/100ps
module pmcs_chk (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic sleep_exec,
  input logic wake_event,
  input logic cpu_clk,
  input logic periph_clk,
  input logic primary_osc_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_cpu_stopped; !cpu_clk [*4]; endsequence
  sequence s_cpu_back; ##[1:40] cpu_clk; endsequence
  property p_rst_clk; $rose(aresetn) |-> ##[1:20] periph_clk; endproperty
  a_rst_clk: assert property (p_rst_clk) else $error("no clock after reset");
  property p_wr; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write response dropped");
  property p_cpu_per; cpu_clk |-> periph_clk; endproperty
  a_cpu_per: assert property (p_cpu_per) else $error("cpu clocked without peripherals");
  property p_sleep; sleep_exec |-> ##[1:40] s_cpu_stopped; endproperty
  a_sleep: assert property (p_sleep) else $error("cpu clock not stopped");
  property p_wake; wake_event |-> s_cpu_back; endproperty
  a_wake: assert property (p_wake) else $error("cpu clock not back");
  property p_rst; $rose(aresetn) |-> primary_osc_enable; endproperty
  a_rst: assert property (p_rst) else $error("primary off");
  property p_rd; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read dropped");
endmodule // pmcs_chk
bind pmcs_clock_switch pmcs_chk chk (.*);

//--- pmcs_osc_model.sv
// oscillator sources facing the switch
`timescale 1ns/100ps
module pmcs_osc_model (
  output pmcs_pkg::pmcs_osc_type osc_in,
  output logic secondary_osc_running
);
  logic p = 1'b0;
  logic sc = 1'b0;
  logic ic = 1'b0;
  // late secondary start, so the first switch to it must wait
  initial begin
    secondary_osc_running = 1'b0;
    #2500;
    secondary_osc_running = 1'b1;
  end
  // free-running sources at periods of 3, 6 and 5 bus clock periods
  always #15 p = ~p;
  always #30 sc = ~sc;
  always #25 ic = ~ic;
  assign osc_in = '{pri: p, sec: sc, intl: ic};
endmodule // pmcs_osc_model

//--- pmcs_clock_switch_tb.sv
// self-checking bench for the clock switch
`timescale 1ns/100ps
module pmcs_clock_switch_tb;
  bit aclk, aresetn, sleep_exec, wake_event, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  bit s_axi_arvalid, s_axi_rready;
  bit [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb = 4'hf;
  bit [31:0] s_axi_wdata, s = 32'h53ba;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_clk;
  logic periph_clk, primary_osc_enable, secondary_osc_enable_out, secondary_osc_running;
  logic internal_osc_block_enable, low_freq_internal_osc_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  pmcs_pkg::pmcs_osc_type osc_in;
  int n_mismatch, compares;
  pmcs_clock_switch #(.OST_COUNT(16)) uut (.*);
  pmcs_osc_model osc (.*);
  always #5 aclk = ~aclk;
  function bit [31:0] xs(bit [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ v << 5;
  endfunction
  task report_and_stop;
    $display("%0d wrong of %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(logic [7:0] v, e);
    compares++;
    if (v !== e) begin n_mismatch++; $display("wrong value %0t %h %h", $time, v, e); end
  endtask
  function bit [7:0] exp_osc(bit idle, bit pri, bit [1:0] sel);
    return {idle, 3'h0, pri, 1'b0, sel};
  endfunction
  // optional write with random spare bits, settle, then one masked read;
  // ready is looked at mid-cycle, where it stands for the coming edge
  task acc(bit w, bit [3:0] a, bit [7:0] d, m, e);
    bit aw_ok, w_ok, b_ok, ar_ok, r_ok;
    bit [7:0] got;
    s = xs(s);
    if (w) begin
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, s[31:8], d, 3'h7};
      do begin
        @(negedge aclk);
        aw_ok = s_axi_awvalid && s_axi_awready === 1'b1;
        w_ok = s_axi_wvalid && s_axi_wready === 1'b1;
        b_ok = s_axi_bvalid === 1'b1;
        @(posedge aclk);
        if (aw_ok) s_axi_awvalid <= 0;
        if (w_ok) s_axi_wvalid <= 0;
      end while (!b_ok);
      s_axi_bready <= 0;
    end
    repeat (99) @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid && s_axi_arready === 1'b1;
      r_ok = s_axi_rvalid === 1'b1;
      got = s_axi_rdata[7:0];
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 0;
    end while (!r_ok);
    s_axi_rready <= 0;
    chk(got & m, e);
  endtask
  task pulse(bit wk);
    @(posedge aclk);
    if (wk) wake_event <= 1;
    else sleep_exec <= 1;
    @(posedge aclk);
    wake_event <= 0;
    sleep_exec <= 0;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    acc(0, 4'h0, 8'h00, 8'h8b, 8'h08);
    acc(1, 4'h4, 8'h08, 8'h48, 8'h08);
    acc(1, 4'h0, 8'h01, 8'h8b, 8'h01);
    acc(0, 4'h4, 8'h00, 8'h40, 8'h40);
    acc(1, 4'h0, 8'h80, 8'h8b, 8'h88);
    pulse(0);
    acc(0, 4'h0, 8'h00, 8'h8b, 8'h88);
    pulse(1);
    acc(1, 4'h0, 8'h00, 8'h8b, 8'h08);
    pulse(0);
    acc(0, 4'h0, 8'h00, 8'h8b, 8'h00);
    chk(primary_osc_enable, 8'h00);
    pulse(1);
    acc(0, 4'h0, 8'h00, 8'h8b, 8'h08);
    repeat (3) begin
      s = xs(s);
      acc(1, 4'h0, {s[0], 7'h00}, 8'h8b, exp_osc(s[0], 1'b1, 2'h0));
    end
    acc(1, 4'h4, 8'h00, 8'h48, 8'h00);
    acc(1, 4'h0, 8'h01, 8'h8b, exp_osc(1'b0, 1'b1, 2'h1));
    acc(1, 4'h0, 8'h03, 8'h8b, exp_osc(1'b0, 1'b0, 2'h3));
    chk(primary_osc_enable, 8'h00);
    chk(internal_osc_block_enable, 8'h01);
    chk(secondary_osc_enable_out, 8'h00);
    acc(1, 4'h8, 8'h14, 8'h77, 8'h14);
    chk(low_freq_internal_osc_enable, 8'h01);
    acc(1, 4'h0, 8'h00, 8'h8b, 8'h08);
    chk(primary_osc_enable, 8'h01);
    report_and_stop;
  end
  initial begin #4e5; n_mismatch++; report_and_stop; end
endmodule // pmcs_clock_switch_tb
